// file: core/mca_pkg.sv
// Constants, encodings and state types shared by the MAC assist block.
package mca_pkg;
  localparam int CLK_HZ        = 100_000_000;
  localparam int TRACE_BAUD_HZ = 500_000;
  localparam int TRACE_DIV     = CLK_HZ / TRACE_BAUD_HZ;
  localparam int LBT_DELAY_US  = 5000;
  localparam int LBT_DELAY_CYC = LBT_DELAY_US * (CLK_HZ / 1_000_000);

  localparam logic [2:0]  MAX_BACKOFFS      = 3'h5;
  localparam int          FRAME_DEPTH       = 128;
  localparam logic [7:0]  FRAME_PAYLOAD_MAX = 8'h7b;
  localparam int          TRACE_DEPTH       = 16;
  localparam logic [7:0]  SEQ_WR_INDEX      = 8'h02;

  localparam logic [31:0] CRC16_POLY    = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY    = 32'hedb8_8320;
  localparam logic [31:0] CRC16_INIT    = 32'h0000_0000;
  localparam logic [31:0] CRC32_INIT    = 32'hffff_ffff;
  localparam logic [31:0] CRC16_RESIDUE = 32'h0000_0000;
  localparam logic [31:0] CRC32_RESIDUE = 32'hdebb_20e3;

  localparam int         FCF_TYPE_LSB   = 0;
  localparam int         FCF_PEND_BIT   = 4;
  localparam int         FCF_DMODE_LSB  = 10;
  localparam logic [2:0] FT_ACK         = 3'h2;
  localparam logic [1:0] DMODE_SHORT    = 2'h2;
  localparam logic [1:0] DMODE_EXT      = 2'h3;
  localparam logic [7:0] IDX_FCF_LO     = 8'h01;
  localparam logic [7:0] IDX_FCF_HI     = 8'h02;
  localparam logic [7:0] IDX_SEQ        = 8'h03;
  localparam logic [7:0] IDX_DST_FIRST  = 8'h06;
  localparam logic [15:0] SHORT_BCAST   = 16'hffff;

  localparam int EV_W          = 5;
  localparam int EV_TX_DONE    = 0;
  localparam int EV_TX_ERROR   = 1;
  localparam int EV_ACK        = 2;
  localparam int EV_ACK_PEND   = 3;
  localparam int EV_RX_FRAME   = 4;

  localparam logic [1:0] FAIL_NONE    = 2'h0;
  localparam logic [1:0] FAIL_BUSY    = 2'h1;
  localparam logic [1:0] FAIL_NO_ACK  = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE, TX_LBT, TX_BACKOFF, TX_LISTEN, TX_SEND, TX_ACK_WAIT
  } mca_tx_state_t;
endpackage

// file: core/mca_pair_buf.sv
// Two-entry buffer with registered output that absorbs one stall of the receiver.
module mca_pair_buf #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic         main_v_r;
  logic         skid_v_r;
  logic [W-1:0] skid_r;
  wire          in_fire  = in_valid && !skid_v_r;
  wire          can_move = out_ready || !main_v_r;

  assign in_ready  = !skid_v_r;
  assign out_valid = main_v_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_v_r <= 1'b0;
      skid_v_r <= 1'b0;
      out_data <= '0;
      skid_r   <= '0;
    end else if (can_move) begin
      if (skid_v_r) begin
        out_data <= skid_r;
        skid_v_r <= 1'b0;
      end else begin
        main_v_r <= in_fire;
        out_data <= in_fire ? in_data : '0;
      end
    end else if (in_fire) begin
      skid_r   <= in_data;
      skid_v_r <= 1'b1;
    end
  end
endmodule

// file: core/mca_mac_assist.sv
// MAC assist: CSMA/LBT channel access, auto-ACK wait, FCS, sync search, filter, trace.
//
// Function
// - Clear channel check compares measured signal strength with the user threshold, any mode.
// - Standard boot mode handles only standard frames, no custom packet options.
// - A frame goes out only after channel access succeeds.
// - Busy during listening starts a random backoff in standard boot mode, else fails at once; at most five backoffs, in symbols.
// - Channel clear for whole listening period leads to transmission.
// - Backoffs exhausted raise transmit failure with channel-busy cause.
// - Listen-before-talk adds a fixed 5 ms delay before the random backoff.
// - With auto-ACK on in standard boot mode, receive for a valid ACK until the timeout ends.
// - ACK in time raises an event chosen by its frame-pending bit.
// - No ACK before timeout raises transmit failure.
// - Generate and check 2- or 4-byte FCS in both boot modes.
// - Search two user sync words, each up to 4 bytes, at once.
// - No FEC decoding; report which sync word matched.
// - Filter received frames on extended and short destination address in standard boot mode.
// - Standard boot mode parses received frame fields by itself.
// - Trace copies TX bytes, RX bytes and status onto one chosen pin while its queue has room; a TX byte wins over an RX byte in the same cycle.
// - Trace can be disabled and never feeds data into the modem.
// - Trace serial rate defaults to 500 kbaud.
// - Trace works only in standard boot mode.
// - Any enabled pending event drives the active-low alert line low.
module mca_mac_assist #(
  parameter int LBT_CYCLES = mca_pkg::LBT_DELAY_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     boot_std,
  input  wire logic                     fcs_4byte,
  input  wire logic                     auto_ack_en,
  input  wire logic                     lbt_en,
  input  wire logic [7:0]               cca_thresh,
  input  wire logic [7:0]               rssi,
  input  wire logic [15:0]              sym_cycles,
  input  wire logic [7:0]               cca_syms,
  input  wire logic [7:0]               backoff_syms,
  input  wire logic [15:0]              ack_timeout_syms,
  input  wire logic                     tx_wr_valid,
  input  wire logic [7:0]               tx_wr_data,
  output logic                          tx_wr_ready,
  input  wire logic                     tx_go,
  output logic                          mod_tx_valid,
  output logic [7:0]                    mod_tx_data,
  output logic                          mod_tx_last,
  input  wire logic                     mod_tx_ready,
  input  wire logic                     rx_bit_valid,
  input  wire logic                     rx_bit,
  input  wire logic [31:0]              sync_word_a,
  input  wire logic [31:0]              sync_word_b,
  input  wire logic [1:0]               sync_bytes,
  input  wire logic [15:0]              own_short_addr,
  input  wire logic [63:0]              own_ext_addr,
  input  wire logic [mca_pkg::EV_W-1:0] ev_enable,
  input  wire logic [mca_pkg::EV_W-1:0] ev_clear,
  output logic [mca_pkg::EV_W-1:0]      ev_pending,
  output logic                          host_alert_line_n,
  output logic                          tx_busy,
  output logic [1:0]                    tx_fail_cause,
  output logic                          channel_busy_exhausted,
  output logic                          cca_busy,
  output logic                          rx_sync_second,
  output logic                          rx_fcs_ok,
  output logic                          rx_addr_ok,
  output logic [7:0]                    rx_len,
  input  wire logic                     trace_en,
  input  wire logic [1:0]               trace_gpio_sel,
  output logic [3:0]                    packet_trace_output
);
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d,
                                           input logic wide);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r  = r >> 1;
      if (fb) begin
        r = r ^ (wide ? mca_pkg::CRC32_POLY : mca_pkg::CRC16_POLY);
      end
    end
    return r;
  endfunction

  // ---------------- Transmit side ----------------
  mca_pkg::mca_tx_state_t st_r;
  logic [7:0]  frame_mem [mca_pkg::FRAME_DEPTH];
  logic [7:0]  len_r;
  logic [7:0]  seq_r;
  logic [7:0]  tx_idx_r;
  logic [31:0] tx_crc_r;
  logic [15:0] wait_r;
  logic [15:0] div_r;
  logic [19:0] lbt_cnt_r;
  logic [2:0]  nb_r;
  logic [15:0] lfsr_r;
  logic        buf_in_ready;

  wire [7:0]  fcs_n     = fcs_4byte ? 8'h04 : 8'h02;
  wire [31:0] crc_init  = fcs_4byte ? mca_pkg::CRC32_INIT : mca_pkg::CRC16_INIT;
  wire        chan_busy = rssi > cca_thresh;
  wire        sym_tick  = (div_r + 16'h0001 >= sym_cycles);
  wire        wait_done = (wait_r == 16'h0000);
  wire [2:0]  rnd_raw   = lfsr_r[2:0];
  wire [2:0]  rnd_per   = (rnd_raw > mca_pkg::MAX_BACKOFFS) ? rnd_raw - 3'h6 : rnd_raw;
  wire [15:0] bo_len    = boot_std ? 16'(rnd_per * backoff_syms) : 16'h0000;
  wire [31:0] crc_fin   = fcs_4byte ? ~tx_crc_r : tx_crc_r;
  wire [7:0]  fcs_pos   = tx_idx_r - len_r - 8'h01;
  wire [7:0]  tx_byte   = (tx_idx_r == 8'h00) ? len_r + fcs_n :
                          (tx_idx_r <= len_r) ? frame_mem[7'(tx_idx_r - 8'h01)] :
                          8'(crc_fin >> {fcs_pos[1:0], 3'b000});
  wire        tx_last   = (tx_idx_r == len_r + fcs_n);
  wire        tx_push   = (st_r == mca_pkg::TX_SEND) && buf_in_ready;
  wire        wr_fire   = tx_wr_valid && tx_wr_ready;
  wire        send_end  = tx_push && tx_last;
  wire        want_ack  = auto_ack_en && boot_std;
  wire        last_try  = (nb_r == mca_pkg::MAX_BACKOFFS - 3'h1) || !boot_std;
  wire        fail_busy = (st_r == mca_pkg::TX_LISTEN) && chan_busy && last_try;
  logic       ack_hit;
  logic       ack_pend;
  wire        ack_to    = (st_r == mca_pkg::TX_ACK_WAIT) && wait_done && !ack_hit;
  wire        tx_finish = fail_busy || ack_to || (send_end && !want_ack) ||
                          ((st_r == mca_pkg::TX_ACK_WAIT) && ack_hit);

  // Frame memory is only written while idle, so the outgoing frame never changes mid-send.
  always_ff @(posedge clk) begin
    if (wr_fire) begin
      frame_mem[7'(len_r)] <= tx_wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_r <= 16'hace1;
      div_r  <= 16'h0000;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      div_r  <= sym_tick ? 16'h0000 : div_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r      <= mca_pkg::TX_IDLE;
      len_r     <= 8'h00;
      seq_r     <= 8'h00;
      tx_idx_r  <= 8'h00;
      tx_crc_r  <= 32'h0000_0000;
      wait_r    <= 16'h0000;
      lbt_cnt_r <= 20'h00000;
      nb_r      <= 3'h0;
    end else begin
      if (wr_fire) begin
        len_r <= len_r + 8'h01;
        if (len_r == mca_pkg::SEQ_WR_INDEX) begin
          seq_r <= tx_wr_data;
        end
      end
      if (st_r != mca_pkg::TX_LBT && sym_tick && !wait_done) begin
        wait_r <= wait_r - 16'h0001;
      end
      unique case (st_r)
        mca_pkg::TX_IDLE: begin
          nb_r <= 3'h0;
          if (tx_go && len_r != 8'h00) begin
            if (lbt_en) begin
              st_r      <= mca_pkg::TX_LBT;
              lbt_cnt_r <= 20'(LBT_CYCLES - 1);
            end else begin
              st_r   <= mca_pkg::TX_BACKOFF;
              wait_r <= bo_len;
            end
          end
        end
        mca_pkg::TX_LBT: begin
          lbt_cnt_r <= lbt_cnt_r - 20'h00001;
          if (lbt_cnt_r == 20'h00000) begin
            st_r   <= mca_pkg::TX_BACKOFF;
            wait_r <= bo_len;
          end
        end
        mca_pkg::TX_BACKOFF: begin
          if (wait_done) begin
            st_r   <= mca_pkg::TX_LISTEN;
            wait_r <= {8'h00, cca_syms};
          end
        end
        mca_pkg::TX_LISTEN: begin
          if (chan_busy) begin
            nb_r <= nb_r + 3'h1;
            if (last_try) begin
              st_r <= mca_pkg::TX_IDLE;
            end else begin
              st_r   <= mca_pkg::TX_BACKOFF;
              wait_r <= bo_len;
            end
          end else if (wait_done) begin
            st_r     <= mca_pkg::TX_SEND;
            tx_idx_r <= 8'h00;
            tx_crc_r <= crc_init;
          end
        end
        mca_pkg::TX_SEND: begin
          if (tx_push) begin
            tx_idx_r <= tx_idx_r + 8'h01;
            if (tx_idx_r != 8'h00 && tx_idx_r <= len_r) begin
              tx_crc_r <= crc_step(tx_crc_r, tx_byte, fcs_4byte);
            end
            if (tx_last) begin
              st_r   <= want_ack ? mca_pkg::TX_ACK_WAIT : mca_pkg::TX_IDLE;
              wait_r <= ack_timeout_syms;
            end
          end
        end
        mca_pkg::TX_ACK_WAIT: begin
          if (ack_hit || wait_done) begin
            st_r <= mca_pkg::TX_IDLE;
          end
        end
      endcase
      if (tx_finish) begin
        len_r <= 8'h00;
      end
    end
  end

  mca_pair_buf #(.W(9)) u_txbuf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (st_r == mca_pkg::TX_SEND),
    .in_data   ({tx_last, tx_byte}),
    .in_ready  (buf_in_ready),
    .out_valid (mod_tx_valid),
    .out_data  ({mod_tx_last, mod_tx_data}),
    .out_ready (mod_tx_ready)
  );

  // ---------------- Receive side ----------------
  logic        hunt_r;
  logic [31:0] sync_sh_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  byte_sh_r;
  logic [7:0]  rx_idx_r;
  logic [7:0]  rx_len_r;
  logic [15:0] fcf_r;
  logic [7:0]  rx_seq_r;
  logic [63:0] dst_r;
  logic [31:0] rx_crc_r;

  wire [31:0] sh_nxt    = {sync_sh_r[30:0], rx_bit};
  wire [31:0] sync_mask = 32'hffff_ffff >> {~sync_bytes, 3'b000};
  wire        match_a   = ((sh_nxt ^ sync_word_a) & sync_mask) == 32'h0000_0000;
  wire        match_b   = ((sh_nxt ^ sync_word_b) & sync_mask) == 32'h0000_0000;
  wire        sync_hit  = rx_bit_valid && hunt_r && (match_a || match_b);
  wire        byte_done = rx_bit_valid && !hunt_r && (bit_cnt_r == 3'h7);
  wire [7:0]  new_byte  = {rx_bit, byte_sh_r[7:1]};
  wire        frame_end = byte_done && (rx_idx_r != 8'h00) && (rx_idx_r == rx_len_r);
  wire [31:0] crc_after = crc_step(rx_crc_r, new_byte, fcs_4byte);
  wire        fcs_good  = crc_after == (fcs_4byte ? mca_pkg::CRC32_RESIDUE
                                                  : mca_pkg::CRC16_RESIDUE);
  wire [1:0]  dmode     = fcf_r[mca_pkg::FCF_DMODE_LSB +: 2];
  wire [7:0]  dst_n     = (dmode == mca_pkg::DMODE_EXT) ? 8'h08 : 8'h02;
  wire        dst_cap   = (rx_idx_r >= mca_pkg::IDX_DST_FIRST) &&
                          (rx_idx_r < mca_pkg::IDX_DST_FIRST + dst_n);
  wire [15:0] dst_short = dst_r[63:48];
  wire        addr_good = !boot_std ||
                          (dmode != mca_pkg::DMODE_SHORT && dmode != mca_pkg::DMODE_EXT) ||
                          (dmode == mca_pkg::DMODE_SHORT &&
                           (dst_short == own_short_addr || dst_short == mca_pkg::SHORT_BCAST)) ||
                          (dmode == mca_pkg::DMODE_EXT && dst_r == own_ext_addr);
  wire        is_ack    = fcf_r[mca_pkg::FCF_TYPE_LSB +: 3] == mca_pkg::FT_ACK;
  assign ack_hit  = frame_end && fcs_good && boot_std && is_ack && (rx_seq_r == seq_r) &&
                    (st_r == mca_pkg::TX_ACK_WAIT);
  assign ack_pend = fcf_r[mca_pkg::FCF_PEND_BIT];
  wire        rx_deliver = frame_end && fcs_good && addr_good && !is_ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hunt_r    <= 1'b1;
      sync_sh_r <= 32'h0000_0000;
      bit_cnt_r <= 3'h0;
      byte_sh_r <= 8'h00;
      rx_idx_r  <= 8'h00;
      rx_len_r  <= 8'h00;
      fcf_r     <= 16'h0000;
      rx_seq_r  <= 8'h00;
      dst_r     <= 64'h0;
      rx_crc_r  <= 32'h0000_0000;
    end else if (rx_bit_valid) begin
      sync_sh_r <= sh_nxt;
      if (sync_hit) begin
        hunt_r    <= 1'b0;
        bit_cnt_r <= 3'h0;
        rx_idx_r  <= 8'h00;
      end else if (!hunt_r) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
        byte_sh_r <= new_byte;
        if (byte_done) begin
          rx_idx_r <= rx_idx_r + 8'h01;
          if (rx_idx_r == 8'h00) begin
            rx_len_r <= new_byte;
            rx_crc_r <= crc_init;
            hunt_r   <= (new_byte == 8'h00);
          end else begin
            rx_crc_r <= crc_after;
            if (rx_idx_r == mca_pkg::IDX_FCF_LO) fcf_r[7:0] <= new_byte;
            if (rx_idx_r == mca_pkg::IDX_FCF_HI) fcf_r[15:8] <= new_byte;
            if (rx_idx_r == mca_pkg::IDX_SEQ) rx_seq_r <= new_byte;
            if (dst_cap) dst_r <= {new_byte, dst_r[63:8]};
            if (frame_end) hunt_r <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------- Events, alert and status ----------------
  logic [mca_pkg::EV_W-1:0] ev_set;
  always_comb begin
    ev_set                       = '0;
    ev_set[mca_pkg::EV_TX_DONE]  = send_end && !want_ack;
    ev_set[mca_pkg::EV_TX_ERROR] = fail_busy || ack_to;
    ev_set[mca_pkg::EV_ACK]      = ack_hit && !ack_pend;
    ev_set[mca_pkg::EV_ACK_PEND] = ack_hit && ack_pend;
    ev_set[mca_pkg::EV_RX_FRAME] = rx_deliver;
  end
  wire [mca_pkg::EV_W-1:0] ev_nxt = (ev_pending & ~ev_clear) | ev_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_pending             <= '0;
      host_alert_line_n      <= 1'b1;
      tx_fail_cause          <= mca_pkg::FAIL_NONE;
      channel_busy_exhausted <= 1'b0;
      cca_busy               <= 1'b0;
      tx_busy                <= 1'b0;
      tx_wr_ready            <= 1'b0;
      rx_sync_second         <= 1'b0;
      rx_fcs_ok              <= 1'b0;
      rx_addr_ok             <= 1'b0;
      rx_len                 <= 8'h00;
    end else begin
      ev_pending        <= ev_nxt;
      host_alert_line_n <= ~|(ev_nxt & ev_enable);
      cca_busy          <= chan_busy;
      tx_busy           <= (st_r != mca_pkg::TX_IDLE);
      tx_wr_ready       <= (st_r == mca_pkg::TX_IDLE) && !tx_go &&
                           (len_r + 8'(wr_fire) < mca_pkg::FRAME_PAYLOAD_MAX);
      if (fail_busy) begin
        tx_fail_cause          <= mca_pkg::FAIL_BUSY;
        channel_busy_exhausted <= 1'b1;
      end else if (ack_to) begin
        tx_fail_cause          <= mca_pkg::FAIL_NO_ACK;
        channel_busy_exhausted <= 1'b0;
      end else if (tx_go && st_r == mca_pkg::TX_IDLE) begin
        tx_fail_cause          <= mca_pkg::FAIL_NONE;
        channel_busy_exhausted <= 1'b0;
      end
      if (sync_hit) rx_sync_second <= !match_a;
      if (frame_end) begin
        rx_fcs_ok  <= fcs_good;
        rx_addr_ok <= addr_good;
        rx_len     <= rx_len_r;
      end
    end
  end

  // ---------------- Packet trace (output only, never read back into the modem) ----------------
  logic [7:0] tr_mem [mca_pkg::TRACE_DEPTH];
  logic [4:0] tr_wp_r;
  logic [4:0] tr_rp_r;
  logic       stat_pend_r;
  logic [7:0] stat_r;
  logic       tr_busy_r;
  logic [9:0] tr_sh_r;
  logic [3:0] tr_bit_r;
  logic [7:0] tr_div_r;

  wire       trace_on = trace_en && boot_std;
  wire       tr_full  = (tr_wp_r[3:0] == tr_rp_r[3:0]) && (tr_wp_r[4] != tr_rp_r[4]);
  wire       tr_empty = (tr_wp_r == tr_rp_r);
  wire       tr_src   = tx_push || byte_done || stat_pend_r;
  wire [7:0] tr_byte  = tx_push ? tx_byte : byte_done ? new_byte : stat_r;
  wire       tr_push  = trace_on && tr_src && !tr_full;
  wire       stat_go  = !tx_push && !byte_done;
  wire       tr_load  = !tr_busy_r && !tr_empty;
  wire       tr_tick  = tr_div_r == 8'(mca_pkg::TRACE_DIV - 1);
  wire       tr_line  = (tr_busy_r && trace_on) ? tr_sh_r[0] : 1'b1;

  always_ff @(posedge clk) begin
    if (tr_push) begin
      tr_mem[tr_wp_r[3:0]] <= tr_byte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tr_wp_r     <= 5'h00;
      tr_rp_r     <= 5'h00;
      stat_pend_r <= 1'b0;
      stat_r      <= 8'h00;
      tr_busy_r   <= 1'b0;
      tr_sh_r     <= 10'h3ff;
      tr_bit_r    <= 4'h0;
      tr_div_r    <= 8'h00;
    end else begin
      // A full trace queue drops bytes rather than stalling the radio.
      if (tr_push) tr_wp_r <= tr_wp_r + 5'h01;
      if (frame_end || send_end) begin
        stat_pend_r <= 1'b1;
        stat_r      <= {frame_end, fcs_good, addr_good, rx_sync_second, tx_fail_cause, 2'b00};
      end else if (stat_pend_r && stat_go) begin
        stat_pend_r <= 1'b0;
      end
      if (tr_load) begin
        tr_sh_r   <= {1'b1, tr_mem[tr_rp_r[3:0]], 1'b0};
        tr_rp_r   <= tr_rp_r + 5'h01;
        tr_busy_r <= 1'b1;
        tr_bit_r  <= 4'h0;
        tr_div_r  <= 8'h00;
      end else if (tr_busy_r) begin
        tr_div_r <= tr_tick ? 8'h00 : tr_div_r + 8'h01;
        if (tr_tick) begin
          tr_sh_r  <= {1'b1, tr_sh_r[9:1]};
          tr_bit_r <= tr_bit_r + 4'h1;
          if (tr_bit_r == 4'h9) tr_busy_r <= 1'b0;
        end
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_trace_pin
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        packet_trace_output[g] <= 1'b1;
      end else begin
        packet_trace_output[g] <= (trace_gpio_sel == 2'(g)) ? tr_line : 1'b1;
      end
    end
  end
endmodule

// file: verification/mca_mac_assist_asserts.sv
// Concurrent checks on the MAC assist top-level ports, bound into the design.
module mca_mac_assist_asserts (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic [7:0]               rssi,
  input wire logic [7:0]               cca_thresh,
  input wire logic                     cca_busy,
  input wire logic [mca_pkg::EV_W-1:0] ev_enable,
  input wire logic [mca_pkg::EV_W-1:0] ev_pending,
  input wire logic                     host_alert_line_n,
  input wire logic [1:0]               tx_fail_cause,
  input wire logic                     channel_busy_exhausted,
  input wire logic                     tx_busy,
  input wire logic                     tx_wr_ready,
  input wire logic                     mod_tx_valid,
  input wire logic [7:0]               mod_tx_data,
  input wire logic                     mod_tx_last,
  input wire logic                     mod_tx_ready,
  input wire logic                     trace_en,
  input wire logic [3:0]               packet_trace_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence stall_s;
    mod_tx_valid && !mod_tx_ready;
  endsequence
  alert_level_a: assert property ($stable(ev_enable) |->
    host_alert_line_n == !(|(ev_pending & ev_enable))) else $error("alert line wrong");
  busy_cause_a: assert property (
    channel_busy_exhausted == (tx_fail_cause == mca_pkg::FAIL_BUSY)) else $error("busy flag wrong");
  cca_compare_a: assert property (!$past(rst) |->
    cca_busy == $past(rssi > cca_thresh)) else $error("channel check wrong");
  stall_hold_a: assert property (stall_s |=>
    mod_tx_valid && $stable(mod_tx_data) && $stable(mod_tx_last)) else $error("stall lost byte");
  last_valid_a: assert property (mod_tx_last |-> mod_tx_valid)
    else $error("last without valid");
  trace_off_a: assert property (!trace_en |=> packet_trace_output == 4'hf)
    else $error("trace active while off");
  busy_refuse_a: assert property (tx_busy |-> !tx_wr_ready)
    else $error("write accepted while busy");
  fail_event_a: assert property ($rose(channel_busy_exhausted) |->
    ev_pending[mca_pkg::EV_TX_ERROR]) else $error("no error event");
endmodule
bind mca_mac_assist mca_mac_assist_asserts u_mca_mac_assist_asserts (.*);

// file: verification/mca_modem_model.sv
// Modem-side sink that takes the transmit stream at once or on alternate cycles.
module mca_modem_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       mod_tx_valid,
  input  wire logic [7:0] mod_tx_data,
  input  wire logic       mod_tx_last,
  output logic            mod_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got [$];
  logic       tick_r;
  assign mod_tx_ready = !slow || tick_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= !tick_r;
      if (mod_tx_valid && mod_tx_ready) got.push_back({mod_tx_last, mod_tx_data});
    end
  end
endmodule

// file: verification/mca_mac_assist_tb.sv
// Bench for the MAC assist: clear send, busy exhaustion, ACK timeout, all-zero five-byte frame receive and general-mode busy.
module mca_mac_assist_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, boot_std, fcs_4byte, auto_ack_en, lbt_en, slow, tx_go, trace_en;
  logic        tx_wr_valid, tx_wr_ready, rx_bit_valid, rx_bit, mod_tx_ready, mod_tx_valid;
  logic        mod_tx_last, host_alert_line_n, tx_busy, channel_busy_exhausted, cca_busy;
  logic        rx_sync_second, rx_fcs_ok, rx_addr_ok;
  logic [7:0]  cca_thresh, rssi, cca_syms, backoff_syms, tx_wr_data, mod_tx_data, rx_len;
  logic [15:0] sym_cycles, ack_timeout_syms, own_short_addr;
  logic [31:0] sync_word_a, sync_word_b;
  logic [63:0] own_ext_addr;
  logic [1:0]  sync_bytes, trace_gpio_sel, tx_fail_cause;
  logic [4:0]  ev_enable, ev_clear, ev_pending;
  logic [3:0]  packet_trace_output;
  int          n_errors = 0;
  int          checks_done = 0;
  mca_mac_assist #(.LBT_CYCLES(50)) u_mca_mac_assist (.*);
  mca_modem_model u_mca_modem_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Loads n bytes, starts the transfer, then waits for idle and a drained buffer.
  task automatic send(input int n);
    int k;
    u_mca_modem_model.got.delete();
    for (int i = 0; i < n; i++) begin
      tx_wr_valid = 1'b1;
      tx_wr_data = 8'h10 + 8'(i);
      while (tx_wr_ready !== 1'b1) step(1);
      step(1);
    end
    tx_wr_valid = 1'b0;
    tx_go = 1'b1;
    step(1);
    tx_go = 1'b0;
    k = 0;
    while (mod_tx_valid !== 1'b1 && k < 600) begin
      step(1);
      k++;
    end
    if (lbt_en) check(k >= 50, 1, "lbt delay");
    while (tx_busy !== 1'b0 && k < 3000) begin
      step(1);
      k++;
    end
    check(k < 3000, 1, "tx idle");
    step(12);
  endtask
  task automatic clear_events();
    ev_clear = 5'h1f;
    step(1);
    ev_clear = 5'h00;
    step(1);
    check(host_alert_line_n, 1, "alert released");
  endtask
  task automatic send_clear();
    send(5);
    check(u_mca_modem_model.got.size(), 8, "byte count");
    check(u_mca_modem_model.got[0], 9'h007, "length byte");
    check(u_mca_modem_model.got[1], 9'h010, "first payload");
    check(u_mca_modem_model.got[7][8], 1, "last flag");
    check(ev_pending, 5'h01, "done event");
    check(host_alert_line_n, 0, "alert low");
    clear_events();
  endtask
  task automatic busy_exhaust();
    rssi = 8'hff;
    lbt_en = 1'b0;
    send(3);
    check(u_mca_modem_model.got.size(), 0, "sent while busy");
    check(tx_fail_cause, mca_pkg::FAIL_BUSY, "busy cause");
    check(ev_pending, 5'h02, "busy error event");
    clear_events();
  endtask
  task automatic ack_timeout();
    {rssi, auto_ack_en, fcs_4byte, slow} = {8'h40, 2'h3, 1'b0};
    send(4);
    check(u_mca_modem_model.got[0], 9'h008, "long fcs length");
    check(tx_fail_cause, mca_pkg::FAIL_NO_ACK, "ack cause");
    check(ev_pending, 5'h02, "ack error event");
    clear_events();
  endtask
  task automatic rx_zero_frame();
    {fcs_4byte, sync_word_a} = {1'b0, 32'h0000_0001};
    rx_bit_valid = 1'b1;
    for (int i = 0; i < 49; i++) begin
      rx_bit = (i == 1 || i == 3);
      step(1);
    end
    rx_bit_valid = 1'b0;
    check(rx_sync_second, 1, "second sync");
    check(rx_len, 8'h05, "rx length");
    check(rx_fcs_ok, 1, "rx fcs");
    check(rx_addr_ok, 1, "rx address");
    check(ev_pending, 5'h10, "rx event");
    clear_events();
  endtask
  task automatic general_busy();
    {boot_std, rssi} = {1'b0, 8'hff};
    send(2);
    check(tx_fail_cause, mca_pkg::FAIL_BUSY, "general busy");
    check(ev_pending, 5'h02, "general error");
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {tx_wr_valid, tx_go, rx_bit_valid, rx_bit, trace_en, fcs_4byte, auto_ack_en} = '0;
    {rst, boot_std, lbt_en, slow} = 4'hf;
    {cca_thresh, rssi, sym_cycles, cca_syms, backoff_syms} = {16'h4000, 16'h0001, 16'h0402};
    {ack_timeout_syms, own_short_addr, sync_word_a, sync_word_b, own_ext_addr} = {16'h0014, 144'h0};
    {sync_bytes, trace_gpio_sel, ev_clear, tx_wr_data} = '0;
    ev_enable = 5'h1f;
    step(3);
    rst = 1'b0;
    step(2);
    send_clear();
    busy_exhaust();
    ack_timeout();
    rx_zero_frame();
    general_busy();
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
